/* File: hw/wesb_pkg.sv */
// Package for the wake event status bank: offsets, widths, reset values.
// Assumes an APB slave with 32-bit data, one aligned word per register.
package wesb_pkg;
  // ----------------------------------------
  // Register indices, widths and reset values
  // ----------------------------------------
  localparam logic [7:0] IDX_STATUS_FOUR = 8'h07;
  localparam logic [7:0] IDX_STATUS_FIVE = 8'h08;
  localparam logic [7:0] IDX_RESERVED = 8'h09;
  localparam logic [7:0] IDX_ENABLE_FOUR = 8'h40;
  localparam logic [7:0] IDX_ENABLE_FIVE = 8'h41;
  localparam logic [7:0] IDX_GLOBAL_ENABLE = 8'h42;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int FLAG_W = 8;
  localparam int NUM_BANKS = 2;
  localparam logic [FLAG_W-1:0] FLAGS_RESET = 8'h00;
  localparam logic [DATA_W-1:0] READ_ZERO = 32'h00000000;
  localparam logic [0:0] GLOBAL_EN_BIT_RESET = 1'h0;
endpackage

/* File: hw/wesb_sync.sv */
// Two-flop synchroniser bank for the wake event pins.
// Assumes pins are asynchronous to the reference clock.
`timescale 1ns/100ps
module wesb_sync #(
  parameter int WIDTH = 16
) (
  input wire logic clk_in,              // Reference clock
  input wire logic rst_b_in,            // Async reset, active low
  input wire logic [WIDTH-1:0] d_in,    // Asynchronous levels
  output logic [WIDTH-1:0] q_out        // Synchronised levels
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  always_comb
  begin
    meta_nxt = d_in;
    sync_nxt = meta_r;
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign q_out = sync_r;
endmodule // wesb_sync

/* File: hw/wesb_top.sv */
// Wake status banks four and five with write-one-to-clear flags on APB.
// Assumes wake event pins are asynchronous levels; an event is a rising edge.
// The standby reset comes only from standby power-on; main resets do not reach it.
`timescale 1ns/100ps
module wesb_top #(
  parameter int FLAG_W = wesb_pkg::FLAG_W,      // Flags per bank
  parameter int NUM_BANKS = wesb_pkg::NUM_BANKS // Banks held here
) (
  input wire logic REF_CLK_IN,                // 25 MHz clock
  input wire logic RST_B_IN,                  // Standby reset, active low
  input wire logic MAIN_RESET_IN,             // Main/soft/hard reset, ignored by flags
  input wire logic [7:0] BANK_FOUR_PINS_IN,   // gpio_30..gpio_61 wake pins
  input wire logic [7:0] BANK_FIVE_PINS_IN,   // gpio_50..gpio_57 wake pins
  input wire logic PSEL_IN,                   // APB select
  input wire logic PENABLE_IN,                // APB enable
  input wire logic PWRITE_IN,                 // APB direction
  input wire logic [11:0] PADDR_IN,           // APB byte address
  input wire logic [31:0] PWDATA_IN,          // APB write data
  output logic [31:0] PRDATA_OUT,             // APB read data
  output logic PREADY_OUT,                    // APB ready
  output logic PSLVERR_OUT,                   // APB error on unmapped address
  output logic WAKE_OUTPUT_N_OUT              // Wake output, active low
);
  localparam int FW = FLAG_W;
  localparam int NB = NUM_BANKS;
  localparam logic READY_LEVEL = 1'b1;
  localparam logic ERR_IDLE = 1'b0;
  localparam logic WAKE_N_IDLE = 1'b1;

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  // Port widths, bank indices and pin order serve two banks of eight only
  generate
    if (FLAG_W != wesb_pkg::FLAG_W || NUM_BANKS != wesb_pkg::NUM_BANKS)
    begin : g_bad_size
      $error("wesb_top serves two banks of eight flags only");
    end
  endgenerate

  // ----------------------------------------
  // Pin synchronisation and edge detection
  // ----------------------------------------
  logic [NB*FW-1:0] pins_sync;
  logic [NB*FW-1:0] pins_prev_r;
  logic [NB*FW-1:0] pins_prev_nxt;
  logic [NB*FW-1:0] events;

  // Bank four pin order gpio_30,31,32,33,41,43,60,61 kept by board wiring
  wesb_sync #(.WIDTH(NB*FW)) u_sync (
    .clk_in(REF_CLK_IN),
    .rst_b_in(RST_B_IN),
    .d_in({BANK_FIVE_PINS_IN, BANK_FOUR_PINS_IN}),
    .q_out(pins_sync)
  );

  assign events = pins_sync & ~pins_prev_r;

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  function automatic logic hit(input logic [11:0] addr, input logic [7:0] idx);
    hit = (addr == {2'h0, idx, 2'h0});
  endfunction

  logic access;
  logic setup;
  logic wr;
  logic rd;
  // Writes land at the access edge; read data and error are prepared at the
  // setup edge so that they stand through the single access cycle
  assign access = PSEL_IN & PENABLE_IN;
  assign setup = PSEL_IN & ~PENABLE_IN;
  assign wr = access & PWRITE_IN;
  assign rd = setup & ~PWRITE_IN;

  logic [FW-1:0] status_r [NB];
  logic [FW-1:0] status_nxt [NB];
  logic [FW-1:0] enable_r [NB];
  logic [FW-1:0] enable_nxt [NB];
  logic global_en_r;
  logic global_en_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic wake_n_r;
  logic wake_n_nxt;
  logic pready_r;
  logic pready_nxt;
  logic mapped;

  // ----------------------------------------
  // Flag banks
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NB; g++)
    begin : g_bank
      logic [7:0] st_idx;
      logic [7:0] en_idx;
      assign st_idx = (g == 0) ? wesb_pkg::IDX_STATUS_FOUR : wesb_pkg::IDX_STATUS_FIVE;
      assign en_idx = (g == 0) ? wesb_pkg::IDX_ENABLE_FOUR : wesb_pkg::IDX_ENABLE_FIVE;
      always_comb
      begin
        logic [FW-1:0] clr;
        clr = (wr && hit(PADDR_IN, st_idx)) ? PWDATA_IN[FW-1:0] : '0;
        // Set beats clear; enables not consulted
        status_nxt[g] = (status_r[g] & ~clr) | events[g*FW +: FW];
        enable_nxt[g] = (wr && hit(PADDR_IN, en_idx)) ? PWDATA_IN[FW-1:0] : enable_r[g];
      end
    end
  endgenerate

  // ----------------------------------------
  // Global enable
  // ----------------------------------------
  always_comb
  begin
    global_en_nxt = global_en_r;
    if (wr && hit(PADDR_IN, wesb_pkg::IDX_GLOBAL_ENABLE))
      global_en_nxt = PWDATA_IN[0];
  end

  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
      global_en_r <= wesb_pkg::GLOBAL_EN_BIT_RESET;
    else
      global_en_r <= global_en_nxt;
  end

  // ----------------------------------------
  // APB answer
  // ----------------------------------------
  // Zero wait states: what the setup cycle computes stands through access
  always_comb
  begin
    mapped = hit(PADDR_IN, wesb_pkg::IDX_STATUS_FOUR) || hit(PADDR_IN, wesb_pkg::IDX_STATUS_FIVE)
      || hit(PADDR_IN, wesb_pkg::IDX_RESERVED) || hit(PADDR_IN, wesb_pkg::IDX_ENABLE_FOUR)
      || hit(PADDR_IN, wesb_pkg::IDX_ENABLE_FIVE) || hit(PADDR_IN, wesb_pkg::IDX_GLOBAL_ENABLE);
    prdata_nxt = wesb_pkg::READ_ZERO;
    if (rd)
    begin
      if (hit(PADDR_IN, wesb_pkg::IDX_STATUS_FOUR))
        prdata_nxt[FW-1:0] = status_r[0];
      else if (hit(PADDR_IN, wesb_pkg::IDX_STATUS_FIVE))
        prdata_nxt[FW-1:0] = status_r[1];
      else if (hit(PADDR_IN, wesb_pkg::IDX_ENABLE_FOUR))
        prdata_nxt[FW-1:0] = enable_r[0];
      else if (hit(PADDR_IN, wesb_pkg::IDX_ENABLE_FIVE))
        prdata_nxt[FW-1:0] = enable_r[1];
      else if (hit(PADDR_IN, wesb_pkg::IDX_GLOBAL_ENABLE))
        prdata_nxt[0] = global_en_r;
    end
    pslverr_nxt = setup & ~mapped;
    pready_nxt = READY_LEVEL;
  end

  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      prdata_r <= wesb_pkg::READ_ZERO;
      pslverr_r <= ERR_IDLE;
      pready_r <= READY_LEVEL;
    end
    else
    begin
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
      pready_r <= pready_nxt;
    end
  end

  // ----------------------------------------
  // Wake output
  // ----------------------------------------
  always_comb
  begin
    logic any;
    any = 1'b0;
    for (int i = 0; i < NB; i++)
      any = any | (|(status_r[i] & enable_r[i]));
    wake_n_nxt = ~(any & global_en_r);
  end

  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
      wake_n_r <= WAKE_N_IDLE;
    else
      wake_n_r <= wake_n_nxt;
  end

  // ----------------------------------------
  // Flags, enables and pin history
  // ----------------------------------------
  // Standby reset only; MAIN_RESET_IN deliberately reaches none of this
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      for (int i = 0; i < NB; i++)
      begin
        status_r[i] <= wesb_pkg::FLAGS_RESET;
        enable_r[i] <= wesb_pkg::FLAGS_RESET;
      end
      pins_prev_r <= '0;
    end
    else
    begin
      for (int i = 0; i < NB; i++)
      begin
        status_r[i] <= status_nxt[i];
        enable_r[i] <= enable_nxt[i];
      end
      pins_prev_r <= pins_prev_nxt;
    end
  end

  assign pins_prev_nxt = pins_sync;
  assign PRDATA_OUT = prdata_r;
  assign PREADY_OUT = pready_r;
  assign PSLVERR_OUT = pslverr_r;
  assign WAKE_OUTPUT_N_OUT = wake_n_r;
endmodule // wesb_top

/* File: tb/wesb_asserts.sv */
// Checker for the status bank ports: APB answers and wake output.
// Bound to wesb_top below; one clock, standby reset only.
`timescale 1ns/100ps
module wesb_asserts (
  input wire logic REF_CLK_IN,
  input wire logic RST_B_IN,
  input wire logic MAIN_RESET_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  input wire logic WAKE_OUTPUT_N_OUT
);
  default clocking @(posedge REF_CLK_IN);
  endclocking
  default disable iff (!RST_B_IN);
  wire logic setup = PSEL_IN && !PENABLE_IN;
  wire logic known = PADDR_IN inside {12'h01C, 12'h020, 12'h024, 12'h100, 12'h104, 12'h108};
  sequence glob_off;
    PSEL_IN && PENABLE_IN && PWRITE_IN && PADDR_IN == 12'h108 && !PWDATA_IN[0];
  endsequence
  rsvd_zero_a: assert property (setup && PADDR_IN == 12'h024 |=> PRDATA_OUT == 32'h0)
    else $error("reserved read not zero");
  upper_zero_a: assert property (PSEL_IN && PENABLE_IN |-> PRDATA_OUT[31:8] == 24'h0)
    else $error("upper read bits set");
  unmap_err_a: assert property (setup && !known |=> PSLVERR_OUT)
    else $error("no error on unmapped address");
  map_ok_a: assert property (setup && known |=> !PSLVERR_OUT)
    else $error("error on mapped address");
  wake_drop_a: assert property (glob_off |-> ##[1:3] WAKE_OUTPUT_N_OUT)
    else $error("wake held after global disable");
  main_rst_a: assert property ($rose(MAIN_RESET_IN) |=> $stable(WAKE_OUTPUT_N_OUT))
    else $error("main reset moved wake output");
  idle_zero_a: assert property (!PSEL_IN && !$past(PSEL_IN) |-> PRDATA_OUT == 32'h0)
    else $error("read data not zero when idle");
  ready_high_a: assert property (PSEL_IN && PENABLE_IN |-> PREADY_OUT)
    else $error("ready low in access phase");
endmodule // wesb_asserts
bind wesb_top wesb_asserts chk_i (.REF_CLK_IN, .RST_B_IN, .MAIN_RESET_IN, .PSEL_IN,
  .PENABLE_IN, .PWRITE_IN, .PADDR_IN, .PWDATA_IN, .PRDATA_OUT, .PREADY_OUT,
  .PSLVERR_OUT, .WAKE_OUTPUT_N_OUT);

/* File: tb/wesb_pins.sv */
// Wake pin model: raises chosen pins for a few cycles.
// Assumes callers start just after a rising clock edge.
`timescale 1ns/100ps
module wesb_pins (
  input wire logic clk_in,      // Reference clock
  output logic [7:0] four_out,  // Bank four pins
  output logic [7:0] five_out   // Bank five pins
);
  initial
  begin
    four_out = 8'h00;
    five_out = 8'h00;
  end
  task automatic pulse(input logic [15:0] m);
    four_out <= m[7:0];
    five_out <= m[15:8];
    repeat (4) @(posedge clk_in);
    four_out <= 8'h00;
    five_out <= 8'h00;
    repeat (2) @(posedge clk_in);
  endtask
endmodule // wesb_pins

/* File: tb/tb_top.sv */
// Testbench: APB scenarios and pin events for the status bank.
// Assumes the zero-wait APB slave and the pin model.
`timescale 1ns/100ps
module tb_top;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic main_rst = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rdat;
  logic [7:0] p4;
  logic [7:0] p5;
  logic pready;
  logic perr;
  logic rerr;
  logic wake_n;
  int bad_count = 0;
  int total_checks = 0;
  always #20 clk = ~clk;
  wesb_pins pins (.clk_in(clk), .four_out(p4), .five_out(p5));
  wesb_top dut (.REF_CLK_IN(clk), .RST_B_IN(rst_b), .MAIN_RESET_IN(main_rst),
    .BANK_FOUR_PINS_IN(p4), .BANK_FIVE_PINS_IN(p5), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(perr), .WAKE_OUTPUT_N_OUT(wake_n));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rdat = prdata;
    rerr = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic banks(input logic [15:0] e);
    logic [7:0] lo;
    apb(1'b0, 12'h01C, 32'h0);
    lo = rdat[7:0];
    apb(1'b0, 12'h020, 32'h0);
    chk("banks", {16'h0, e}, {rdat[23:0], lo});
  endtask
  task automatic wr2(input logic [15:0] d);
    apb(1'b1, 12'h01C, {24'h0, d[7:0]});
    apb(1'b1, 12'h020, {24'h0, d[15:8]});
  endtask
  task automatic wk(input logic e);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("wake", {31'h0, e}, {31'h0, wake_n});
    @(posedge clk);
  endtask
  task automatic t_map;
    logic [15:0] m;
    for (int i = 0; i < 16; i++)
    begin
      m = 16'h0001 << i;
      pins.pulse(m);
      wr2(~m);
      banks(m);
      wr2(m);
      banks(16'h0000);
    end
    $display("mapping test done");
  endtask
  task automatic t_race;
    fork
      pins.pulse(16'h0002);
      begin
        @(posedge clk);
        apb(1'b1, 12'h01C, 32'h02);
      end
    join
    banks(16'h0002);
    wr2(16'h0002);
    banks(16'h0000);
    $display("set over clear test done");
  endtask
  task automatic t_rsvd;
    apb(1'b1, 12'h024, 32'hFFFFFFFF);
    apb(1'b0, 12'h024, 32'h0);
    chk("reserved", 32'h0, {rdat[31:1], rdat[0] | rerr});
    apb(1'b0, 12'h0FC, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, rerr});
    pins.pulse(16'h8001);
    main_rst <= 1'b1;
    repeat (3) @(posedge clk);
    main_rst <= 1'b0;
    banks(16'h8001);
    $display("reserved and main reset test done");
  endtask
  task automatic t_wake;
    apb(1'b1, 12'h100, 32'h1);
    wk(1'b1);
    apb(1'b1, 12'h108, 32'h1);
    wk(1'b0);
    apb(1'b1, 12'h01C, 32'hFE);
    wk(1'b0);
    apb(1'b1, 12'h01C, 32'h01);
    wk(1'b1);
    pins.pulse(16'h0001);
    wk(1'b0);
    apb(1'b1, 12'h108, 32'h0);
    wk(1'b1);
    $display("wake test done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #400000;
    bad_count++;
    wrap_up;
  end
  initial
  begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    banks(16'h0000);
    t_map;
    t_race;
    t_rsvd;
    t_wake;
    wrap_up;
  end
endmodule // tb_top
